//--- logic/bssp_pkg.sv
// constants shared by the buffered synchronous serial port
// assumes apb byte addresses, 32-bit data, one register per word
package bssp_pkg;
    // ------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [11:0] IDX_CTRL_ONE   = 12'h020;
    localparam logic [11:0] IDX_CTRL_TWO   = 12'h021;
    localparam logic [11:0] IDX_STATE      = 12'h027;
    localparam logic [11:0] IDX_BUF_FIRST  = 12'hFF8;
    localparam logic [11:0] IDX_BUF_LAST   = 12'hFFF;
    // ------------------------------------------------------------
    // control one fields
    // ------------------------------------------------------------
    localparam int          C1_START_BIT   = 7;
    localparam int          C1_MODE_LSB    = 3;
    localparam int          C1_CLK_LSB     = 0;
    localparam logic [2:0]  CLK_EXTERNAL   = 3'h7;
    // ------------------------------------------------------------
    // control two fields
    // ------------------------------------------------------------
    localparam int          C2_LOWDIV_BIT  = 6;
    localparam int          C2_HIGHDIV_BIT = 5;
    localparam int          C2_WAIT_LSB    = 3;
    localparam int          C2_COUNT_LSB   = 0;
    // ------------------------------------------------------------
    // status layout and reset values
    // ------------------------------------------------------------
    localparam int          ST_ACTIVE_BIT  = 7;
    localparam int          ST_SHIFT_BIT   = 6;
    localparam logic [5:0]  ST_UNUSED      = 6'h3F;
    localparam logic [7:0]  CTRL_RESET     = 8'h00;
    // ------------------------------------------------------------
    // transfer modes
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_TX4   = 3'b000,
        MODE_TX8   = 3'b001,
        MODE_RX4   = 3'b010,
        MODE_RX8   = 3'b011,
        MODE_TXRX8 = 3'b101
    } bssp_mode_t;
    // ------------------------------------------------------------
    // clock divider exponents and wait lengths
    // ------------------------------------------------------------
    localparam logic [3:0]  EXP_RATE0      = 4'hD;
    localparam logic [3:0]  EXP_RATE1      = 4'h8;
    localparam logic [3:0]  EXP_RATE2      = 4'h6;
    localparam logic [3:0]  EXP_RATE3      = 4'h5;
    localparam logic [3:0]  SLOW_HALF_MASK = 4'hF;
    localparam logic [4:0]  WAIT_BASE      = 5'h02;
endpackage : bssp_pkg

//--- logic/bssp_top.sv
// buffered clocked serial port with eight-word buffer and apb registers
// assumes pins are synchronous to pclk and slow_tick is a one-cycle
// enable at the low-frequency source rate
`timescale 1ns/100ps

// What this block does
// - eight-word buffer moves up to 64 bits without software between words
// - transmit-only leaves input free; receive-only never drives output pin
// - three-bit word count in control two; buffer at eight data addresses
// - after counted words: buffer empty in transmit, full otherwise
// - internal 8-bit receive or duplex inserts selectable wait per word
// - status bit7 transfer active, bit6 shifting, low bits read one
// - three-bit clock select picks internal rate or external clock pin
// - internal rate from high or low source by divider settings
// - internal clock drives clock pin high when a transfer starts
// - internal clock halts and holds shifting while software lags
// - outgoing bits change on falling edge of the clock pin
// - incoming bits are captured on rising edge of the clock pin
// - 4-bit mode shifts low nibble, received upper nibble is zero
// - every word moves least significant bit first
// - three-bit mode field picks transmit, receive or duplex and size
// - start bit begins transfer; transmit data loaded beforehand
// - clearing start finishes current word; its end stores it when receiving and clears active
module bssp_top (
    // ------------------------------------------------------------
    // clock and reset
    // ------------------------------------------------------------
    input  wire logic        pclk,
    input  wire logic        presetn,
    // ------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [15:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // ------------------------------------------------------------
    // low-frequency source enable
    // ------------------------------------------------------------
    input  wire logic        slow_tick,
    // ------------------------------------------------------------
    // serial pins
    // ------------------------------------------------------------
    input  wire logic        serial_in_pin,
    output logic             serial_out_pin,
    output logic             serial_out_oe,
    input  wire logic        serial_clock_in,
    output logic             serial_clock_out,
    output logic             serial_clock_oe,
    // ------------------------------------------------------------
    // event
    // ------------------------------------------------------------
    output logic             buffer_event_irq
);
    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_LOAD  = 3'b001,
        ST_SHIFT = 3'b010,
        ST_GAP   = 3'b011,
        ST_HOLD  = 3'b100
    } bssp_state_t;

    bssp_state_t      state;
    logic [7:0]       data_buffer_area [8];
    logic [7:0]       serial_control_one;
    logic [7:0]       serial_control_two;
    logic [7:0]       shreg;
    logic [2:0]       bit_cnt;
    logic [2:0]       word_idx;
    logic [15:0]      div_cnt;
    logic [3:0]       slow_cnt;
    logic [4:0]       gap_cnt;
    logic             clk_prev;
    logic             svc_wr;
    logic             svc_rd;
    logic             transfer_active_flag;
    logic             shift_active_flag;

    logic             start_stop_bit;
    logic [2:0]       transfer_mode_select;
    logic [2:0]       clk_sel;
    logic             ext_clk;
    logic             is_tx;
    logic             is_rx;
    logic             four_bit;
    logic [2:0]       last_bit;
    logic             half_tick;
    logic             fall_ev;
    logic             rise_ev;
    logic             word_end;
    logic             apb_done;
    logic [11:0]      reg_idx;
    logic             hit_buf;
    logic             mapped;
    logic             serviced;
    logic [3:0]       rate_exp;

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    // all low bits below the half-period exponent set
    function automatic logic tick_at(input logic [15:0] cnt,
                                     input logic [3:0]  e);
        logic [15:0] mask;
        mask    = 16'(16'h0001 << (e - 4'h1)) - 16'h0001;
        tick_at = (cnt & mask) == mask;
    endfunction : tick_at

    function automatic logic in_buf(input logic [11:0] idx);
        in_buf = idx >= bssp_pkg::IDX_BUF_FIRST
              && idx <= bssp_pkg::IDX_BUF_LAST;
    endfunction : in_buf

    assign start_stop_bit       = serial_control_one[bssp_pkg::C1_START_BIT];
    assign transfer_mode_select =
        serial_control_one[bssp_pkg::C1_MODE_LSB +: 3];
    assign clk_sel   = serial_control_one[bssp_pkg::C1_CLK_LSB +: 3];
    assign ext_clk   = clk_sel == bssp_pkg::CLK_EXTERNAL;
    assign is_tx     = transfer_mode_select != 3'(bssp_pkg::MODE_RX4)
                    && transfer_mode_select != 3'(bssp_pkg::MODE_RX8);
    assign is_rx     = transfer_mode_select != 3'(bssp_pkg::MODE_TX4)
                    && transfer_mode_select != 3'(bssp_pkg::MODE_TX8);
    assign four_bit  = transfer_mode_select == 3'(bssp_pkg::MODE_TX4)
                    || transfer_mode_select == 3'(bssp_pkg::MODE_RX4);
    assign last_bit  = four_bit ? 3'h3 : 3'h7;

    // ------------------------------------------------------------
    // internal rate selection
    // ------------------------------------------------------------
    always_comb begin
        unique case (clk_sel[1:0])
            2'b00:   rate_exp = bssp_pkg::EXP_RATE0;
            2'b01:   rate_exp = bssp_pkg::EXP_RATE1;
            2'b10:   rate_exp = bssp_pkg::EXP_RATE2;
            2'b11:   rate_exp = bssp_pkg::EXP_RATE3;
        endcase
        // high divider doubles the period
        rate_exp = rate_exp
                 + {3'h0, serial_control_two[bssp_pkg::C2_HIGHDIV_BIT]};
    end

    // slowest rate may run from the low-frequency source instead
    assign half_tick = (clk_sel[1:0] == 2'b00
                        && serial_control_two[bssp_pkg::C2_LOWDIV_BIT])
                     ? (slow_tick && slow_cnt == bssp_pkg::SLOW_HALF_MASK)
                     : tick_at(div_cnt, rate_exp);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt  <= 16'h0000;
            slow_cnt <= 4'h0;
        end else begin
            div_cnt <= div_cnt + 16'h0001;
            if (slow_tick) begin
                slow_cnt <= slow_cnt + 4'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // serial clock edges
    // ------------------------------------------------------------
    // external pin is taken as synchronous; one stage finds edges
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_prev <= 1'b1;
        end else begin
            clk_prev <= serial_clock_in;
        end
    end

    always_comb begin
        fall_ev = 1'b0;
        rise_ev = 1'b0;
        if (state == ST_SHIFT) begin
            if (ext_clk) begin
                fall_ev = clk_prev && !serial_clock_in;
                rise_ev = !clk_prev && serial_clock_in;
            end else if (half_tick) begin
                fall_ev = serial_clock_out;
                rise_ev = !serial_clock_out;
            end
        end
    end

    assign word_end = rise_ev && bit_cnt == last_bit;

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    assign reg_idx  = paddr[13:2];
    assign hit_buf  = in_buf(reg_idx) && paddr[15:14] == 2'b00;
    assign mapped   = hit_buf || (paddr[15:14] == 2'b00
                      && (reg_idx == bssp_pkg::IDX_CTRL_ONE
                       || reg_idx == bssp_pkg::IDX_CTRL_TWO
                       || reg_idx == bssp_pkg::IDX_STATE));
    assign apb_done = psel && penable && pready;

    // one wait state keeps read data registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !mapped;
            prdata  <= 32'h0000_0000;
            if (psel && penable && !pready && !pwrite) begin
                if (hit_buf) begin
                    prdata[7:0] <= data_buffer_area[reg_idx[2:0]];
                end else if (reg_idx == bssp_pkg::IDX_CTRL_ONE) begin
                    prdata[7:0] <= serial_control_one;
                end else if (reg_idx == bssp_pkg::IDX_CTRL_TWO) begin
                    prdata[7:0] <= serial_control_two;
                end else if (reg_idx == bssp_pkg::IDX_STATE) begin
                    prdata[7:0] <= {transfer_active_flag,
                                    shift_active_flag,
                                    bssp_pkg::ST_UNUSED};
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_control_one <= bssp_pkg::CTRL_RESET;
            serial_control_two <= bssp_pkg::CTRL_RESET;
        end else if (apb_done && pwrite
                     && paddr[15:14] == 2'b00) begin
            if (reg_idx == bssp_pkg::IDX_CTRL_ONE) begin
                serial_control_one <= pwdata[7:0];
            end
            // count changes mid-transfer are not guarded
            if (reg_idx == bssp_pkg::IDX_CTRL_TWO) begin
                serial_control_two <= pwdata[7:0];
            end
        end
    end

    // ------------------------------------------------------------
    // service tracking for the automatic wait
    // ------------------------------------------------------------
    // a new access wins over the clear on leaving the wait
    // idle clears too: preloads belong to the first burst
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            svc_wr <= 1'b0;
            svc_rd <= 1'b0;
        end else begin
            if (apb_done && hit_buf && pwrite) begin
                svc_wr <= 1'b1;
            end else if (state == ST_IDLE
                         || (state == ST_HOLD && serviced)) begin
                svc_wr <= 1'b0;
            end
            if (apb_done && hit_buf && !pwrite) begin
                svc_rd <= 1'b1;
            end else if (state == ST_IDLE
                         || (state == ST_HOLD && serviced)) begin
                svc_rd <= 1'b0;
            end
        end
    end

    // duplex needs both a read and a write before resuming
    assign serviced = (!is_tx || svc_wr) && (!is_rx || svc_rd);

    // ------------------------------------------------------------
    // transfer sequencer
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state                <= ST_IDLE;
            word_idx             <= 3'h0;
            bit_cnt              <= 3'h0;
            gap_cnt              <= 5'h00;
            buffer_event_irq     <= 1'b0;
            transfer_active_flag <= 1'b0;
            shift_active_flag    <= 1'b0;
        end else begin
            buffer_event_irq <= 1'b0;
            unique case (state)
                ST_IDLE: begin
                    word_idx <= 3'h0;
                    if (start_stop_bit) begin
                        transfer_active_flag <= 1'b1;
                        state                <= ST_LOAD;
                    end
                end
                ST_LOAD: begin
                    bit_cnt           <= 3'h0;
                    shift_active_flag <= 1'b1;
                    state             <= ST_SHIFT;
                end
                ST_SHIFT: begin
                    if (rise_ev) begin
                        bit_cnt <= bit_cnt + 3'h1;
                    end
                    if (word_end) begin
                        shift_active_flag <= 1'b0;
                        word_idx          <= word_idx + 3'h1;
                        if (!start_stop_bit) begin
                            state                <= ST_IDLE;
                            transfer_active_flag <= 1'b0;
                        end else if (word_idx == serial_control_two[
                                 bssp_pkg::C2_COUNT_LSB +: 3]) begin
                            buffer_event_irq <= 1'b1;
                            word_idx         <= 3'h0;
                            state            <= ext_clk ? ST_LOAD
                                                        : ST_HOLD;
                        end else if (!ext_clk && !four_bit
                                     && is_rx) begin
                            gap_cnt <= 5'(bssp_pkg::WAIT_BASE
                                       << serial_control_two[
                                       bssp_pkg::C2_WAIT_LSB +: 2]);
                            state   <= ST_GAP;
                        end else begin
                            state <= ST_LOAD;
                        end
                    end
                end
                ST_GAP: begin
                    if (half_tick) begin
                        gap_cnt <= gap_cnt - 5'h01;
                        if (gap_cnt == 5'h01) begin
                            state <= ST_LOAD;
                        end
                    end
                end
                ST_HOLD: begin
                    // clock stays stopped until software catches up
                    if (!start_stop_bit) begin
                        state                <= ST_IDLE;
                        transfer_active_flag <= 1'b0;
                    end else if (serviced) begin
                        state <= ST_LOAD;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // shift register and buffer
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shreg <= 8'h00;
        end else if (state == ST_LOAD) begin
            shreg <= data_buffer_area[word_idx];
        end else if (rise_ev) begin
            // capture enters at the top of the active width
            if (four_bit) begin
                shreg <= {4'h0, serial_in_pin, shreg[3:1]};
            end else begin
                shreg <= {serial_in_pin, shreg[7:1]};
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 8; i++) begin
                data_buffer_area[i] <= 8'h00;
            end
        end else if (word_end && is_rx) begin
            // the word just completed, upper nibble cleared in 4-bit
            if (four_bit) begin
                data_buffer_area[word_idx] <= {4'h0, serial_in_pin,
                                               shreg[3:1]};
            end else begin
                data_buffer_area[word_idx] <= {serial_in_pin,
                                               shreg[7:1]};
            end
        end else if (apb_done && pwrite && hit_buf) begin
            data_buffer_area[reg_idx[2:0]] <= pwdata[7:0];
        end
    end

    // ------------------------------------------------------------
    // serial pins
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_clock_out <= 1'b1;
            serial_clock_oe  <= 1'b0;
            serial_out_pin   <= 1'b1;
            serial_out_oe    <= 1'b0;
        end else begin
            serial_clock_oe <= transfer_active_flag && !ext_clk;
            serial_out_oe   <= transfer_active_flag && is_tx;
            if (state == ST_IDLE || state == ST_LOAD) begin
                serial_clock_out <= 1'b1;
            end else if (!ext_clk && state == ST_SHIFT && half_tick) begin
                serial_clock_out <= !serial_clock_out;
            end
            // previous bit held until the falling edge
            if (fall_ev && is_tx) begin
                serial_out_pin <= shreg[0];
            end
        end
    end
endmodule : bssp_top

//--- sim/bssp_checker.sv
// pin and apb checks for the serial port top
// assumes binding into bssp_top, one pclk domain
`timescale 1ns/100ps
module bssp_checker (
    // apb side
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // serial pins
    input wire logic        serial_out_pin,
    input wire logic        serial_out_oe,
    input wire logic        serial_clock_out,
    input wire logic        serial_clock_oe,
    input wire logic        buffer_event_irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_READY_ACCESS: assert property (pready |-> psel && penable
        && $past(penable) && !$past(pready)) else $error("bad ready");
    AST_UNMAPPED: assert property (pready && paddr == 16'h0000
        |-> pslverr) else $error("no slave error");
    AST_HIGH_ZERO: assert property (pready
        |-> prdata[31:8] == 24'h000000) else $error("upper bits set");
    AST_STATE_ONES: assert property (
        pready && !pwrite && paddr[13:2] == bssp_pkg::IDX_STATE
        |-> prdata[5:0] == 6'h3F) else $error("state low bits");
    AST_START_HIGH: assert property (
        $rose(serial_clock_oe) |-> serial_clock_out) else $error("start");
    AST_IDLE_HIGH: assert property (
        !serial_clock_oe |-> serial_clock_out) else $error("idle clock");
    AST_OUT_ON_FALL: assert property (
        serial_clock_oe && serial_out_oe && $past(serial_out_oe)
        && $changed(serial_out_pin) |-> !serial_clock_out)
        else $error("out moved on high clock");
    // fastest rate is 32 pclk a bit, so 8 low cycles is safe
    AST_LOW_PHASE: assert property (
        $fell(serial_clock_out) |-> !serial_clock_out [*8])
        else $error("short low phase");
    AST_IRQ_PULSE: assert property (
        buffer_event_irq |=> !buffer_event_irq) else $error("irq long");
    AST_IRQ_HOLD: assert property (
        buffer_event_irq && serial_clock_oe |-> serial_clock_out)
        else $error("clock low at irq");
endmodule : bssp_checker

bind bssp_top bssp_checker i_chk (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .prdata, .pready, .pslverr, .serial_out_pin,
    .serial_out_oe, .serial_clock_out, .serial_clock_oe, .buffer_event_irq);

//--- sim/bssp_partner.sv
// peer device clocked by the port's clock pin
// assumes internal clock mode; pins move at pclk edges
`timescale 1ns/100ps
module bssp_partner (
    // serial link
    input  wire logic        sck,
    input  wire logic        sck_oe,
    input  wire logic        sdo,
    output logic             sdi,
    // test data
    input  wire logic [7:0]  tx_word,
    output logic      [15:0] rx_bits
);
    int idx = 0;
    initial sdi = 1'b1;
    initial rx_bits = 16'h0000;
    always @(posedge sck_oe) idx = 0;
    // released line flips so no stale bit passes for data
    always @(negedge sck_oe) sdi <= ~sdi;
    always @(negedge sck) if (sck_oe === 1'b1) begin
        sdi <= tx_word[idx[2:0]];
        idx = idx + 1;
    end
    always @(posedge sck) if (sck_oe === 1'b1)
        rx_bits <= {sdo, rx_bits[15:1]};
endmodule : bssp_partner

//--- sim/bssp_tb_top.sv
// bench: apb table, tx8 and rx4 bursts, then two external-clock tx4 words
// assumes the checker binds itself to bssp_top
`timescale 1ns/100ps
module bssp_tb_top;
    typedef struct packed {
        logic        wr;
        logic [15:0] a;
        logic [31:0] d;
        logic [31:0] e;
        logic        err;
    } bssp_row_t;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0;
    logic        penable = 1'b0, pwrite = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, so, so_oe, sck, sck_oe, si, irq, er;
    logic        xck = 1'b1;
    logic [7:0]  xb = 8'h00;
    logic [15:0] prx;
    int          errors = 0, check_count = 0, irqs = 0;
    bssp_row_t   rows [8] = '{'{1'b1, 16'h3FE0, 32'h5A, 32'h0, 1'b0},
        '{1'b1, 16'h3FFC, 32'hC3, 32'h0, 1'b0},
        '{1'b0, 16'h3FE0, 32'h0, 32'h5A, 1'b0},
        '{1'b0, 16'h3FFC, 32'h0, 32'hC3, 1'b0},
        '{1'b1, 16'h009C, 32'hFF, 32'h0, 1'b0},
        '{1'b0, 16'h009C, 32'h0, 32'h3F, 1'b0},
        '{1'b1, 16'h0000, 32'hFF, 32'h0, 1'b1},
        '{1'b0, 16'h0000, 32'h0, 32'h0, 1'b1}};
    always #4 pclk = ~pclk;
    // counted off the falling edge, clear of the rising edge at which the bench reads the total
    always @(negedge pclk) if (irq === 1'b1) irqs++;
    bssp_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .slow_tick(1'b0),
        .serial_in_pin(si), .serial_out_pin(so), .serial_out_oe(so_oe),
        .serial_clock_in(xck), .serial_clock_out(sck),
        .serial_clock_oe(sck_oe), .buffer_event_irq(irq));
    bssp_partner i_peer (.sck, .sck_oe, .sdo(so), .sdi(si),
        .tx_word(8'h96), .rx_bits(prx));
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        check_count++;
        if (g !== e) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic apb(logic w, logic [15:0] a, logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) errors++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wait_for(ref logic s, input logic v);
        int n;
        n = 0;
        while (s !== v && n < 5000) begin
            @(posedge pclk);
            n++;
        end
        chk("wait", {31'h0, v}, {31'h0, s});
    endtask : wait_for
    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : complete_run
    initial begin
        repeat (20) @(posedge pclk);
        chk("clock pin", 32'h1, {31'h0, sck});
        presetn <= 1'b1;
        foreach (rows[i]) begin
            apb(rows[i].wr, rows[i].a, rows[i].d);
            chk("slave error", {31'h0, rows[i].err}, {31'h0, er});
            if (!rows[i].wr) chk("read data", rows[i].e, rd);
        end
        $display("test registers done");
        apb(1'b1, 16'h3FE0, 32'hA5);
        apb(1'b1, 16'h3FE4, 32'h3C);
        apb(1'b1, 16'h0084, 32'h01);
        apb(1'b1, 16'h0080, 32'h8B);
        apb(1'b0, 16'h009C, 32'h0);
        chk("active flag", 32'h80, rd & 32'h80);
        wait_for(irq, 1'b1);
        chk("wire bits", 32'h3CA5, {16'h0, prx});
        chk("irq count", 32'h1, irqs);
        apb(1'b0, 16'h009C, 32'h0);
        chk("hold state", 32'hBF, rd);
        apb(1'b1, 16'h0080, 32'h0B);
        wait_for(sck_oe, 1'b0);
        apb(1'b0, 16'h009C, 32'h0);
        chk("state idle", 32'h3F, rd);
        $display("test tx8 done");
        apb(1'b1, 16'h0084, 32'h00);
        apb(1'b1, 16'h0080, 32'h93);
        wait_for(irq, 1'b1);
        chk("out enable", 32'h0, {31'h0, so_oe});
        apb(1'b0, 16'h3FE0, 32'h0);
        chk("nibble", 32'h06, rd);
        apb(1'b1, 16'h0080, 32'h13);
        wait_for(sck_oe, 1'b0);
        apb(1'b0, 16'h3FE0, 32'h0);
        chk("last word", 32'h09, rd);
        $display("test rx4 done");
        apb(1'b1, 16'h3FE0, 32'h05);
        apb(1'b1, 16'h0080, 32'h87);
        for (int i = 0; i < 8; i++) begin
            // stop lands between words: one dummy word follows
            if (i == 4) apb(1'b1, 16'h0080, 32'h07);
            repeat (4) @(posedge pclk);
            xck <= 1'b0;
            repeat (4) @(posedge pclk);
            xck <= 1'b1;
            xb = {so, xb[7:1]};
        end
        chk("external bits", 32'h55, {24'h0, xb});
        apb(1'b0, 16'h009C, 32'h0);
        chk("external idle", 32'h3F, rd);
        chk("irq total", 32'h3, irqs);
        $display("test external done");
        complete_run;
    end
    initial begin
        repeat (20000) @(posedge pclk);
        errors++;
        complete_run;
    end
endmodule : bssp_tb_top
